// file: inc/pgtm_regs.svh
`ifndef PGTM_REGS_SVH
`define PGTM_REGS_SVH

// Register indices; byte address is four times the index
`define PGTM_IDX_OUT2_RAIL 8'hA8
`define PGTM_IDX_OUT2_MISC 8'hA9
`define PGTM_IDX_OUT3_RAIL 8'hAA
`define PGTM_ADR_W 12

// Rail mask fields
`define PGTM_BIT_LINEAR_A2 7
`define PGTM_BIT_SWITCH_A1 6
`define PGTM_BIT_STEP_DOWN_HI 5
`define PGTM_BIT_STEP_DOWN_LO 0

// Enable-input and miscellaneous mask fields
`define PGTM_BIT_ENABLE_5 7
`define PGTM_BIT_ENABLE_4 6
`define PGTM_BIT_ENABLE_2 5
`define PGTM_BIT_ENABLE_1 4
`define PGTM_BIT_TERMINATION 3
`define PGTM_BIT_SHARED_B2_A1 2
`define PGTM_BIT_SWITCH_B1 1
`define PGTM_BIT_LINEAR_A3 0

// Per-variant reset patterns
`define PGTM_RST_OUT2_RAIL_V0 8'hDF
`define PGTM_RST_OUT2_RAIL_V1 8'hEB
`define PGTM_RST_OUT2_RAIL_V2 8'hDF
`define PGTM_RST_OUT2_RAIL_V3 8'hC0
`define PGTM_RST_OUT2_MISC_V0 8'h3F
`define PGTM_RST_OUT2_MISC_V1 8'hFC
`define PGTM_RST_OUT2_MISC_V2 8'hFF
`define PGTM_RST_OUT2_MISC_V3 8'hC7
`define PGTM_RST_OUT3_RAIL_V0 8'hE0
`define PGTM_RST_OUT3_RAIL_V1 8'h5C
`define PGTM_RST_OUT3_RAIL_V2 8'hF7
`define PGTM_RST_OUT3_RAIL_V3 8'hDF

`endif

// file: inc/pgtm_pkg.sv
package pgtm_pkg;
   // Variant 3 routes the shared contributor from load switch B2
   typedef enum logic [1:0] {
      PGTM_VARIANT_0,
      PGTM_VARIANT_1,
      PGTM_VARIANT_2,
      PGTM_VARIANT_3
   } pgtm_variant_t;

   typedef logic [7:0] pgtm_mask_t;

   typedef enum logic [1:0] {
      PGTM_REG_OUT2_RAIL,
      PGTM_REG_OUT2_MISC,
      PGTM_REG_OUT3_RAIL
   } pgtm_reg_sel_t;
endpackage

// file: hw/pgtm_tree.sv
`timescale 1ns/10ps
module pgtm_tree #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Contributors and their exclude bits
   input wire logic [WIDTH-1:0] good_i,
   input wire logic [WIDTH-1:0] exclude_i,
   // Aggregated power good
   output logic pg_o
);
   // Low until the first evaluation so the pin never glitches high out of reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pg_o <= 1'b0;
      end else begin
         pg_o <= &(good_i | exclude_i);
      end
   end
endmodule

// file: hw/pgtm_top.sv
`timescale 1ns/10ps
`include "pgtm_regs.svh"

// Notes on behaviour
// - Output-two rail mask bit 7 includes linear regulator A2 when 0.
// - Output-two rail mask bit 6 includes load switch A1 when 0.
// - Output-two rail mask bits 5..0 gate step-down rails 6..1.
// - Output-two misc mask bits 7..4 gate enable inputs 5,4,2,1.
// - Output-two misc mask bit 3 gates the termination regulator.
// - Misc bit 2 gates switch B2 or linear A1 by variant.
// - Output-two misc mask bit 1 gates load switch B1.
// - Output-two misc mask bit 0 gates linear regulator A3.
// - Output-three rail mask bit 7 gates linear regulator A2.
// - Output-three rail mask bit 6 gates load switch A1.
// - Output-three rail mask bits 5..0 gate step-down rails 6..1.
// - Misc mask at A9h, output-three rail mask at AAh, all bits read/write.
// - Every mask bit loads a variant-specific pattern at reset.
module pgtm_top
   import pgtm_pkg::*;
#(
   parameter pgtm_variant_t VARIANT = PGTM_VARIANT_0
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`PGTM_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Power-good contributors, high means good
   input wire logic [5:0] pg_step_down_rail_i,
   input wire logic pg_linear_reg_a1_i,
   input wire logic pg_linear_reg_a2_i,
   input wire logic pg_linear_reg_a3_i,
   input wire logic pg_load_switch_a1_i,
   input wire logic pg_load_switch_b1_i,
   input wire logic pg_load_switch_b2_i,
   input wire logic pg_termination_i,
   // Enable input pin levels
   input wire logic enable_input_1_i,
   input wire logic enable_input_2_i,
   input wire logic enable_input_4_i,
   input wire logic enable_input_5_i,
   // Power-good output pins
   output logic power_good_output_two_o,
   output logic power_good_output_three_o
);

   function automatic pgtm_mask_t reset_value(input pgtm_reg_sel_t sel);
      pgtm_mask_t v;
      v = 8'h00;
      unique case (sel)
         PGTM_REG_OUT2_RAIL: begin
            unique case (VARIANT)
               PGTM_VARIANT_0: v = `PGTM_RST_OUT2_RAIL_V0;
               PGTM_VARIANT_1: v = `PGTM_RST_OUT2_RAIL_V1;
               PGTM_VARIANT_2: v = `PGTM_RST_OUT2_RAIL_V2;
               PGTM_VARIANT_3: v = `PGTM_RST_OUT2_RAIL_V3;
            endcase
         end
         PGTM_REG_OUT2_MISC: begin
            unique case (VARIANT)
               PGTM_VARIANT_0: v = `PGTM_RST_OUT2_MISC_V0;
               PGTM_VARIANT_1: v = `PGTM_RST_OUT2_MISC_V1;
               PGTM_VARIANT_2: v = `PGTM_RST_OUT2_MISC_V2;
               PGTM_VARIANT_3: v = `PGTM_RST_OUT2_MISC_V3;
            endcase
         end
         PGTM_REG_OUT3_RAIL: begin
            unique case (VARIANT)
               PGTM_VARIANT_0: v = `PGTM_RST_OUT3_RAIL_V0;
               PGTM_VARIANT_1: v = `PGTM_RST_OUT3_RAIL_V1;
               PGTM_VARIANT_2: v = `PGTM_RST_OUT3_RAIL_V2;
               PGTM_VARIANT_3: v = `PGTM_RST_OUT3_RAIL_V3;
            endcase
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [`PGTM_ADR_W-1:0] byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   localparam pgtm_mask_t OUT2_RAIL_RST = reset_value(PGTM_REG_OUT2_RAIL);
   localparam pgtm_mask_t OUT2_MISC_RST = reset_value(PGTM_REG_OUT2_MISC);
   localparam pgtm_mask_t OUT3_RAIL_RST = reset_value(PGTM_REG_OUT3_RAIL);

   pgtm_mask_t out2_rail_reg;
   pgtm_mask_t out2_misc_reg;
   pgtm_mask_t out3_rail_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic bus_req;
   logic wr_strobe;
   logic hit_out2_rail;
   logic hit_out2_misc;
   logic hit_out3_rail;
   logic shared_good;
   pgtm_mask_t out2_rail_good;
   pgtm_mask_t out2_misc_good;
   pgtm_mask_t out3_rail_good;

   assign bus_req = wb_cyc_i & wb_stb_i;
   // Write lands on the edge that samples ack, as classic Wishbone expects
   assign wr_strobe = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
   assign hit_out2_rail = (wb_adr_i == byte_addr(`PGTM_IDX_OUT2_RAIL));
   assign hit_out2_misc = (wb_adr_i == byte_addr(`PGTM_IDX_OUT2_MISC));
   assign hit_out3_rail = (wb_adr_i == byte_addr(`PGTM_IDX_OUT3_RAIL));

   // One wait state; ack drops the cycle after it was given
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   // Unmapped addresses answer with zero and drop writes
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_out2_rail) begin
         rdata_next = {24'h00_0000, out2_rail_reg};
      end else if (hit_out2_misc) begin
         rdata_next = {24'h00_0000, out2_misc_reg};
      end else if (hit_out3_rail) begin
         rdata_next = {24'h00_0000, out3_rail_reg};
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_req & ~ack_reg) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out2_rail_reg <= OUT2_RAIL_RST;
      end else if (wr_strobe & hit_out2_rail) begin
         out2_rail_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out2_misc_reg <= OUT2_MISC_RST;
      end else if (wr_strobe & hit_out2_misc) begin
         out2_misc_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out3_rail_reg <= OUT3_RAIL_RST;
      end else if (wr_strobe & hit_out3_rail) begin
         out3_rail_reg <= wb_dat_i[7:0];
      end
   end

   // Contributor vectors laid out bit for bit like their masks
   assign shared_good = (VARIANT == PGTM_VARIANT_3) ? pg_load_switch_b2_i
                                                    : pg_linear_reg_a1_i;

   always_comb begin
      out2_rail_good = 8'h00;
      out2_rail_good[`PGTM_BIT_LINEAR_A2] = pg_linear_reg_a2_i;
      out2_rail_good[`PGTM_BIT_SWITCH_A1] = pg_load_switch_a1_i;
      out2_rail_good[`PGTM_BIT_STEP_DOWN_HI:`PGTM_BIT_STEP_DOWN_LO] = pg_step_down_rail_i;
   end

   always_comb begin
      out2_misc_good = 8'h00;
      out2_misc_good[`PGTM_BIT_ENABLE_5] = enable_input_5_i;
      out2_misc_good[`PGTM_BIT_ENABLE_4] = enable_input_4_i;
      out2_misc_good[`PGTM_BIT_ENABLE_2] = enable_input_2_i;
      out2_misc_good[`PGTM_BIT_ENABLE_1] = enable_input_1_i;
      out2_misc_good[`PGTM_BIT_TERMINATION] = pg_termination_i;
      out2_misc_good[`PGTM_BIT_SHARED_B2_A1] = shared_good;
      out2_misc_good[`PGTM_BIT_SWITCH_B1] = pg_load_switch_b1_i;
      out2_misc_good[`PGTM_BIT_LINEAR_A3] = pg_linear_reg_a3_i;
   end

   // Output three shares the rail layout of output two
   assign out3_rail_good = out2_rail_good;

   pgtm_tree #(
      .WIDTH(16)
   ) u_tree_two (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .good_i({out2_misc_good, out2_rail_good}),
      .exclude_i({out2_misc_reg, out2_rail_reg}),
      .pg_o(power_good_output_two_o)
   );

   pgtm_tree #(
      .WIDTH(8)
   ) u_tree_three (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .good_i(out3_rail_good),
      .exclude_i(out3_rail_reg),
      .pg_o(power_good_output_three_o)
   );

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   chk_out2_linear_a2: assert property (
      (!out2_rail_reg[7] && !pg_linear_reg_a2_i) |=> !power_good_output_two_o)
      else $error("output two ignored a failing linear regulator A2");

   chk_out2_switch_a1: assert property (
      (!out2_rail_reg[6] && !pg_load_switch_a1_i) |=> !power_good_output_two_o)
      else $error("output two ignored a failing load switch A1");

   chk_out2_step_down: assert property (
      (|(~out2_rail_reg[5:0] & ~pg_step_down_rail_i)) |=> !power_good_output_two_o)
      else $error("output two ignored a failing included step-down rail");

   chk_out2_enable_pins: assert property (
      (|(~out2_misc_reg[7:4] & ~{enable_input_5_i, enable_input_4_i,
                                 enable_input_2_i, enable_input_1_i}))
      |=> !power_good_output_two_o)
      else $error("output two ignored a low included enable input");

   chk_out2_termination: assert property (
      (!out2_misc_reg[3] && !pg_termination_i) |=> !power_good_output_two_o)
      else $error("output two ignored a failing termination regulator");

   chk_out2_shared_source: assert property (
      (!out2_misc_reg[2] && ((VARIANT == PGTM_VARIANT_3) ? !pg_load_switch_b2_i
                                                         : !pg_linear_reg_a1_i))
      |=> !power_good_output_two_o)
      else $error("output two ignored the failing shared contributor");

   chk_out2_switch_b1: assert property (
      (!out2_misc_reg[1] && !pg_load_switch_b1_i) |=> !power_good_output_two_o)
      else $error("output two ignored a failing load switch B1");

   chk_out2_linear_a3: assert property (
      (!out2_misc_reg[0] && !pg_linear_reg_a3_i) |=> !power_good_output_two_o)
      else $error("output two ignored a failing linear regulator A3");

   chk_out3_linear_a2: assert property (
      (!out3_rail_reg[7] && !pg_linear_reg_a2_i) |=> !power_good_output_three_o)
      else $error("output three ignored a failing linear regulator A2");

   chk_out3_switch_a1: assert property (
      (!out3_rail_reg[6] && !pg_load_switch_a1_i) |=> !power_good_output_three_o)
      else $error("output three ignored a failing load switch A1");

   chk_out3_step_down: assert property (
      (|(~out3_rail_reg[5:0] & ~pg_step_down_rail_i)) |=> !power_good_output_three_o)
      else $error("output three ignored a failing included step-down rail");

   chk_misc_write_read: assert property (
      (wr_strobe && hit_out2_misc) |=> (out2_misc_reg == $past(wb_dat_i[7:0])))
      else $error("misc mask did not take the written byte");

   chk_out3_readback: assert property (
      (wb_ack_o && !wb_we_i && hit_out3_rail && $past(bus_req))
      |-> wb_dat_o == {24'h00_0000, out3_rail_reg})
      else $error("output three mask read returned the wrong value");

   chk_reset_pattern: assert property (
      $past(rst_i) |-> (out2_rail_reg == OUT2_RAIL_RST && out2_misc_reg == OUT2_MISC_RST
                        && out3_rail_reg == OUT3_RAIL_RST))
      else $error("mask registers did not load the variant pattern");

   chk_out2_all_good: assert property (
      (&({out2_misc_good, out2_rail_good} | {out2_misc_reg, out2_rail_reg}))
      |=> power_good_output_two_o)
      else $error("output two low although every included contributor is good");

   chk_out3_all_good: assert property (
      (&(out3_rail_good | out3_rail_reg)) |=> power_good_output_three_o)
      else $error("output three low although every included contributor is good");

   chk_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

endmodule

// file: verification/pgtm_host_model.sv
`timescale 1ns/10ps
module pgtm_host_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Power-good pins from the device
   input wire logic pg_two_i,
   input wire logic pg_three_i,
   // Levels as the host last sampled them
   output logic seen_two_o,
   output logic seen_three_o
);
   // One sample a cycle; a real supervisor would debounce on top
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen_two_o <= 1'h0;
         seen_three_o <= 1'h0;
      end else begin
         seen_two_o <= pg_two_i;
         seen_three_o <= pg_three_i;
      end
   end
endmodule

// file: verification/tb_power_good_tree_mask.sv
`timescale 1ns/10ps
`include "pgtm_regs.svh"
module tb_power_good_tree_mask;
   import pgtm_pkg::*;
   logic ref_clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic [31:0] rd;
   logic [31:0] lfsr = 32'h4E27;
   logic ack;
   logic [7:0] c_rail = 8'hFF;
   logic [7:0] c_misc = 8'hFF;
   logic b2 = 1'h1;
   logic pg2;
   logic pg3;
   logic seen2;
   logic seen3;
   logic [31:0] dat_r3;
   logic [31:0] rd3;
   logic ack3;
   logic pg2_v3;
   logic pg3_v3;
   logic v3_on = 1'h0;
   pgtm_mask_t m2;
   pgtm_mask_t mm;
   pgtm_mask_t m3;
   int fail_count = 0;
   int comparisons = 0;

   always #2 ref_clk_i = ~ref_clk_i;

   pgtm_top dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .pg_step_down_rail_i(c_rail[5:0]), .pg_load_switch_a1_i(c_rail[6]),
      .pg_linear_reg_a2_i(c_rail[7]), .pg_linear_reg_a3_i(c_misc[0]),
      .pg_load_switch_b1_i(c_misc[1]), .pg_linear_reg_a1_i(c_misc[2]),
      .pg_termination_i(c_misc[3]), .enable_input_1_i(c_misc[4]),
      .enable_input_2_i(c_misc[5]), .enable_input_4_i(c_misc[6]),
      .enable_input_5_i(c_misc[7]), .pg_load_switch_b2_i(b2),
      .power_good_output_two_o(pg2), .power_good_output_three_o(pg3)
   );

   // Second copy shares the bus; its shared contributor comes from load switch B2
   pgtm_top #(
      .VARIANT(PGTM_VARIANT_3)
   ) dut_v3_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r3), .wb_ack_o(ack3),
      .pg_step_down_rail_i(c_rail[5:0]), .pg_load_switch_a1_i(c_rail[6]),
      .pg_linear_reg_a2_i(c_rail[7]), .pg_linear_reg_a3_i(c_misc[0]),
      .pg_load_switch_b1_i(c_misc[1]), .pg_linear_reg_a1_i(c_misc[2]),
      .pg_termination_i(c_misc[3]), .enable_input_1_i(c_misc[4]),
      .enable_input_2_i(c_misc[5]), .enable_input_4_i(c_misc[6]),
      .enable_input_5_i(c_misc[7]), .pg_load_switch_b2_i(b2),
      .power_good_output_two_o(pg2_v3), .power_good_output_three_o(pg3_v3)
   );

   pgtm_host_model host_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pg_two_i(pg2), .pg_three_i(pg3),
      .seen_two_o(seen2), .seen_three_o(seen3)
   );

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Shared contributor is linear A1, or load switch B2 in variant 3
   function automatic logic exp_two(input pgtm_mask_t r, input pgtm_mask_t m, input logic v3);
      logic [7:0] c;
      c = c_misc;
      if (v3) begin
         c[2] = b2;
      end
      return (&(c_rail | r)) & (&(c | m));
   endfunction

   task end_sim;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= s;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (ack !== 1'h1) begin
         fail_count++;
         $display("Error bus ack never came");
         end_sim;
      end else begin
         check("ack_v3", {31'h0, ack3}, 32'h1);
         rd = dat_r;
         rd3 = dat_r3;
         cyc <= 1'h0;
         stb <= 1'h0;
         we <= 1'h0;
         @(posedge ref_clk_i);
      end
   endtask

   task rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
      wb(1'h0, a, 32'h0, 4'h0);
      check(name, rd, {24'h0, exp});
   endtask

   task set_masks;
      wb(1'h1, 12'h2A0, {24'h0, m2}, 4'h1);
      wb(1'h1, 12'h2A4, {24'h0, mm}, 4'h1);
      wb(1'h1, 12'h2A8, {24'h0, m3}, 4'h1);
   endtask

   task drive(input logic [7:0] r, input logic [7:0] m, input logic b);
      @(posedge ref_clk_i);
      c_rail <= r;
      c_misc <= m;
      b2 <= b;
   endtask

   // Three edges: output flops sample, host samples, one spare
   task settle;
      repeat (3) @(posedge ref_clk_i);
      #1;
      check("pg_two", {31'h0, seen2}, {31'h0, exp_two(m2, mm, 1'h0)});
      check("pg_three", {31'h0, seen3}, {31'h0, &(c_rail | m3)});
      if (v3_on) begin
         check("pg_two_v3", {31'h0, pg2_v3}, {31'h0, exp_two(m2, mm, 1'h1)});
         check("pg_three_v3", {31'h0, pg3_v3}, {31'h0, &(c_rail | m3)});
      end
   endtask

   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      rd_chk("rail2_reset", 12'h2A0, 8'hDF);
      check("rail2_reset_v3", rd3, 32'h0000_00C0);
      rd_chk("misc2_reset", 12'h2A4, 8'h3F);
      check("misc2_reset_v3", rd3, 32'h0000_00C7);
      rd_chk("rail3_reset", 12'h2A8, 8'hE0);
      check("rail3_reset_v3", rd3, 32'h0000_00DF);
      m2 = 8'hDF;
      mm = 8'h3F;
      m3 = 8'hE0;
      settle;
      // From the next set_masks on both copies hold the same masks
      v3_on = 1'h1;
      $display("test reset done");
      // Include one contributor, fail it, then exclude it again
      for (int k = 0; k < 24; k++) begin
         m2 = 8'hFF;
         mm = 8'hFF;
         m3 = 8'hFF;
         if (k < 8) m2[k] = 1'h0;
         else if (k < 16) mm[k - 8] = 1'h0;
         else m3[k - 16] = 1'h0;
         set_masks;
         lfsr = lfsr_next(lfsr);
         drive(~(m2 ^ m3 ^ 8'hFF) | ~m2 & ~m3, mm, lfsr[0]);
         drive(m2 & m3, mm, lfsr[0]);
         settle;
         m2 = 8'hFF;
         mm = 8'hFF;
         m3 = 8'hFF;
         set_masks;
         settle;
      end
      $display("test single contributor done");
      for (int i = 0; i < 60; i++) begin
         lfsr = lfsr_next(lfsr);
         m2 = lfsr[7:0] | lfsr[15:8];
         mm = lfsr[15:8] | lfsr[23:16];
         m3 = lfsr[23:16] | lfsr[31:24];
         set_masks;
         rd_chk("rail2_rw", 12'h2A0, m2);
         rd_chk("misc2_rw", 12'h2A4, mm);
         rd_chk("rail3_rw", 12'h2A8, m3);
         drive(lfsr[7:0] | lfsr[31:24], lfsr[23:16] | lfsr[7:0], lfsr[9]);
         settle;
      end
      $display("test random done");
      wb(1'h1, 12'h2AC, {24'h0, ~mm}, 4'h1);
      wb(1'h1, 12'h2A0, {24'h0, ~m2}, 4'h0);
      rd_chk("unmapped", 12'h2AC, 8'h00);
      rd_chk("rail2_kept", 12'h2A0, m2);
      rd_chk("misc2_kept", 12'h2A4, mm);
      rd_chk("rail3_kept", 12'h2A8, m3);
      $display("test refused done");
      @(posedge ref_clk_i);
      rst_i <= 1'h1;
      @(posedge ref_clk_i);
      #1;
      check("pg_two_in_reset", {31'h0, pg2}, 32'h0);
      check("pg_three_in_reset", {31'h0, pg3}, 32'h0);
      @(posedge ref_clk_i);
      rst_i <= 1'h0;
      rd_chk("misc2_rereset", 12'h2A4, 8'h3F);
      check("misc2_rereset_v3", rd3, 32'h0000_00C7);
      rd_chk("rail3_rereset", 12'h2A8, 8'hE0);
      check("rail3_rereset_v3", rd3, 32'h0000_00DF);
      $display("test second reset done");
      end_sim;
   end
endmodule
